/* File: rtl/rcf_pkg.sv */
package rcf_pkg;

  // ****************************************
  // Flag positions in the reset cause register
  // ****************************************
  localparam int FLAG_W        = 10;
  localparam int BIT_BROWNOUT  = 0;
  localparam int BIT_POWER_ON  = 1;
  localparam int BIT_SLEEP     = 2;
  localparam int BIT_IDLE      = 3;
  localparam int BIT_WATCHDOG  = 4;
  localparam int BIT_SOFTWARE  = 5;
  localparam int BIT_EXT_PIN   = 6;
  localparam int BIT_ILLEGAL   = 7;
  localparam int BIT_TRAP_CONF = 8;
  localparam int BIT_CLK_FAIL  = 9;

  // ****************************************
  // Program counter
  // ****************************************
  localparam int                PC_W        = 24;
  localparam logic [PC_W-1:0]   PC_RESET    = 24'h000000;
  localparam logic [PC_W-1:0]   PC_TRAP     = 24'h000004;
  localparam logic [PC_W-1:0]   PC_STEP     = 24'h000002;

  // ****************************************
  // Register map, 32-bit words
  // ****************************************
  localparam int                ADDR_W       = 4;
  localparam logic [ADDR_W-1:0] OFF_CAUSE    = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_PC       = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_LAST_EVT = 4'h8;
  localparam logic [31:0]       BAD_ADDR_RD  = 32'hDEADBEEF;
  localparam logic [FLAG_W-1:0] FLAGS_RESET  = 10'h003;

  // Event codes, lowest code wins when several arrive together
  typedef enum logic [3:0] {
    RCF_EV_NONE      = 4'h0,
    RCF_EV_POWER_ON  = 4'h1,
    RCF_EV_BROWNOUT  = 4'h2,
    RCF_EV_PIN_RUN   = 4'h3,
    RCF_EV_PIN_SLEEP = 4'h4,
    RCF_EV_PIN_IDLE  = 4'h5,
    RCF_EV_WDT_RESET = 4'h6,
    RCF_EV_TRAP_CONF = 4'h7,
    RCF_EV_ILLEGAL   = 4'h8,
    RCF_EV_SOFTWARE  = 4'h9,
    RCF_EV_CLK_FAIL  = 4'hA,
    RCF_EV_WDT_WAKE  = 4'hB,
    RCF_EV_INT_WAKE  = 4'hC
  } rcf_event_t;

  // Bus slave states, Gray along the path
  typedef enum logic [1:0] {
    RCF_BUS_IDLE = 2'b00,
    RCF_BUS_ACK  = 2'b01
  } rcf_bus_state_t;

endpackage : rcf_pkg

/* File: rtl/rcf_event_if.sv */
interface rcf_event_if;
  rcf_pkg::rcf_event_t             evt;
  logic [rcf_pkg::PC_W-1:0]        vector;

  modport src
  (
    output evt,
    output vector
  );
  modport dst
  (
    input  evt,
    input  vector
  );
endinterface : rcf_event_if

/* File: rtl/rcf_event_arb.sv */
module rcf_event_arb
(
  input  wire logic                      clock,
  input  wire logic                      nrst,
  input  wire logic                      power_on_evt,
  input  wire logic                      brownout_evt,
  input  wire logic                      master_clear_pin_n,
  input  wire logic                      cpu_in_sleep,
  input  wire logic                      cpu_in_idle,
  input  wire logic                      watchdog_timeout,
  input  wire logic                      software_reset,
  input  wire logic                      int_wake,
  input  wire logic [rcf_pkg::PC_W-1:0]  int_vector,
  input  wire logic                      clock_fail_trap,
  input  wire logic                      trap_conflict,
  input  wire logic                      illegal_op,
  rcf_event_if.src                       ev
);

  // ****************************************
  // Pin synchroniser and edge detect
  // ****************************************
  logic pin_meta_reg;
  logic pin_sync_reg;
  logic pin_prev_reg;
  logic pin_meta_next;
  logic pin_sync_next;
  logic pin_prev_next;
  logic pin_fall;

  always_comb
  begin
    pin_meta_next = ~master_clear_pin_n;
    pin_sync_next = pin_meta_reg;
    pin_prev_next = pin_sync_reg;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
      pin_prev_reg <= 1'b0;
    end
    else
    begin
      pin_meta_reg <= pin_meta_next;
      pin_sync_reg <= pin_sync_next;
      pin_prev_reg <= pin_prev_next;
    end
  end

  // One event per assertion of the pin
  assign pin_fall = pin_sync_reg & ~pin_prev_reg;

  // ****************************************
  // Priority select, resets ahead of wake-ups
  // ****************************************
  always_comb
  begin
    ev.vector = int_vector;
    if (power_on_evt)
      ev.evt = rcf_pkg::RCF_EV_POWER_ON;
    else if (brownout_evt)
      ev.evt = rcf_pkg::RCF_EV_BROWNOUT;
    else if (pin_fall && cpu_in_sleep)
      ev.evt = rcf_pkg::RCF_EV_PIN_SLEEP;
    else if (pin_fall && cpu_in_idle)
      ev.evt = rcf_pkg::RCF_EV_PIN_IDLE;
    else if (pin_fall)
      ev.evt = rcf_pkg::RCF_EV_PIN_RUN;
    else if (watchdog_timeout && !cpu_in_sleep)
      ev.evt = rcf_pkg::RCF_EV_WDT_RESET;
    else if (trap_conflict)
      ev.evt = rcf_pkg::RCF_EV_TRAP_CONF;
    else if (illegal_op)
      ev.evt = rcf_pkg::RCF_EV_ILLEGAL;
    else if (software_reset)
      ev.evt = rcf_pkg::RCF_EV_SOFTWARE;
    else if (clock_fail_trap)
      ev.evt = rcf_pkg::RCF_EV_CLK_FAIL;
    else if (watchdog_timeout)
      ev.evt = rcf_pkg::RCF_EV_WDT_WAKE;
    else if (int_wake && cpu_in_sleep)
      ev.evt = rcf_pkg::RCF_EV_INT_WAKE;
    else
      ev.evt = rcf_pkg::RCF_EV_NONE;
  end

endmodule : rcf_event_arb

/* File: rtl/rcf_bus_slave.sv */
module rcf_bus_slave
(
  input  wire logic                          clock,
  input  wire logic                          nrst,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  output logic                               waitrequest,
  output logic                               accept
);

  // ****************************************
  // One wait state per access
  // ****************************************
  rcf_pkg::rcf_bus_state_t state_reg;
  rcf_pkg::rcf_bus_state_t state_next;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      rcf_pkg::RCF_BUS_IDLE:
        if (avs_read || avs_write)
          state_next = rcf_pkg::RCF_BUS_ACK;
      rcf_pkg::RCF_BUS_ACK:
        state_next = rcf_pkg::RCF_BUS_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      state_reg <= rcf_pkg::RCF_BUS_IDLE;
    else
      state_reg <= state_next;
  end

  // Waitrequest for the next cycle, the parent registers it so the pin comes from a flop
  assign accept      = (state_reg == rcf_pkg::RCF_BUS_ACK) && (avs_read || avs_write);
  assign waitrequest = (state_next != rcf_pkg::RCF_BUS_ACK);

endmodule : rcf_bus_slave

/* File: rtl/rcf_reset_cause.sv */
// Summary of operation
// - Software reads and writes every reset cause flag over the bus.
// - Power-on: PC zero, set power-on and brownout, clear all others.
// - Brown-out: PC zero, set brownout, clear power-on, keep others.
// - Pin reset running: PC zero, set pin, clear software/watchdog/idle/sleep.
// - Software reset: PC zero, set software, clear pin/watchdog/idle/sleep.
// - Pin reset in sleep: PC zero, set pin and sleep, clear watchdog/idle.
// - Pin reset in idle: PC zero, set pin and idle, clear watchdog/sleep.
// - Watchdog reset: PC zero, set watchdog, clear pin/software/idle/sleep.
// - Watchdog wake: PC plus two, set watchdog and sleep, keep others.
// - Interrupt wake: PC to vector, set sleep, keep others.
// - Clock failure trap: PC to trap location, flags unchanged.
// - Trap conflict: PC zero, set trap conflict flag, keep others.
// - Illegal operation: PC zero, set illegal flag, keep others.
//
// Implementation choices: the Avalon-MM slave port and the register addresses.
module rcf_reset_cause
(
  input  wire logic                          clock,
  input  wire logic                          nrst,
  input  wire logic                          power_on_evt,
  input  wire logic                          brownout_evt,
  input  wire logic                          master_clear_pin_n,
  input  wire logic                          cpu_in_sleep,
  input  wire logic                          cpu_in_idle,
  input  wire logic                          watchdog_timeout,
  input  wire logic                          software_reset,
  input  wire logic                          int_wake,
  input  wire logic [rcf_pkg::PC_W-1:0]      int_vector,
  input  wire logic                          clock_fail_trap,
  input  wire logic                          trap_conflict,
  input  wire logic                          illegal_op,
  input  wire logic [rcf_pkg::PC_W-1:0]      current_pc,
  output logic                               pc_load,
  output logic [rcf_pkg::PC_W-1:0]           pc_value,
  output logic                               core_reset,
  input  wire logic [rcf_pkg::ADDR_W-1:0]    avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [31:0]                   avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output logic [31:0]                        avs_readdata,
  output logic                               avs_waitrequest
);

  // ****************************************
  // Event arbitration and bus handshake
  // ****************************************
  rcf_event_if ev ();
  logic accept;
  logic wait_comb;

  rcf_event_arb u_arb
  (
    .clock              (clock),
    .nrst               (nrst),
    .power_on_evt       (power_on_evt),
    .brownout_evt       (brownout_evt),
    .master_clear_pin_n (master_clear_pin_n),
    .cpu_in_sleep       (cpu_in_sleep),
    .cpu_in_idle        (cpu_in_idle),
    .watchdog_timeout   (watchdog_timeout),
    .software_reset     (software_reset),
    .int_wake           (int_wake),
    .int_vector         (int_vector),
    .clock_fail_trap    (clock_fail_trap),
    .trap_conflict      (trap_conflict),
    .illegal_op         (illegal_op),
    .ev                 (ev)
  );

  rcf_bus_slave u_bus
  (
    .clock       (clock),
    .nrst        (nrst),
    .avs_read    (avs_read),
    .avs_write   (avs_write),
    .waitrequest (wait_comb),
    .accept      (accept)
  );

  // ****************************************
  // State
  // ****************************************
  logic [rcf_pkg::FLAG_W-1:0] flags_reg;
  logic [rcf_pkg::FLAG_W-1:0] flags_next;
  logic                       pc_load_reg;
  logic                       pc_load_next;
  logic [rcf_pkg::PC_W-1:0]   pc_value_reg;
  logic [rcf_pkg::PC_W-1:0]   pc_value_next;
  logic                       core_reset_reg;
  logic                       core_reset_next;
  logic [3:0]                 last_evt_reg;
  logic [3:0]                 last_evt_next;
  logic [31:0]                rdata_reg;
  logic [31:0]                rdata_next;
  logic                       wait_reg;
  logic                       wait_next;

  function automatic logic [rcf_pkg::FLAG_W-1:0] upd
  (
    input logic [rcf_pkg::FLAG_W-1:0] f,
    input logic [rcf_pkg::FLAG_W-1:0] set_m,
    input logic [rcf_pkg::FLAG_W-1:0] clr_m
  );
    upd = (f & ~clr_m) | set_m;
  endfunction : upd

  function automatic logic [rcf_pkg::FLAG_W-1:0] bm(input int b);
    bm = rcf_pkg::FLAG_W'(1) << b;
  endfunction : bm

  // ****************************************
  // Next state: software write first, then event
  // ****************************************
  always_comb
  begin
    logic [rcf_pkg::FLAG_W-1:0] base;
    logic [rcf_pkg::FLAG_W-1:0] sw_clr;
    base = flags_reg;
    sw_clr = bm(rcf_pkg::BIT_WATCHDOG) | bm(rcf_pkg::BIT_IDLE) | bm(rcf_pkg::BIT_SLEEP);
    // Event applies over a same-cycle write so it is never lost
    if (accept && avs_write && avs_address == rcf_pkg::OFF_CAUSE && avs_byteenable[0])
      base[7:0] = avs_writedata[7:0];
    if (accept && avs_write && avs_address == rcf_pkg::OFF_CAUSE && avs_byteenable[1])
      base[rcf_pkg::FLAG_W-1:8] = avs_writedata[rcf_pkg::FLAG_W-1:8];
    flags_next      = base;
    pc_load_next    = 1'b1;
    pc_value_next   = rcf_pkg::PC_RESET;
    core_reset_next = 1'b1;
    last_evt_next   = ev.evt;
    unique case (ev.evt)
      rcf_pkg::RCF_EV_POWER_ON:
        flags_next = bm(rcf_pkg::BIT_POWER_ON) | bm(rcf_pkg::BIT_BROWNOUT);
      rcf_pkg::RCF_EV_BROWNOUT:
        flags_next = upd(base, bm(rcf_pkg::BIT_BROWNOUT), bm(rcf_pkg::BIT_POWER_ON));
      rcf_pkg::RCF_EV_PIN_RUN:
        flags_next = upd(base, bm(rcf_pkg::BIT_EXT_PIN), sw_clr | bm(rcf_pkg::BIT_SOFTWARE));
      rcf_pkg::RCF_EV_SOFTWARE:
        flags_next = upd(base, bm(rcf_pkg::BIT_SOFTWARE), sw_clr | bm(rcf_pkg::BIT_EXT_PIN));
      rcf_pkg::RCF_EV_PIN_SLEEP:
        flags_next = upd(base, bm(rcf_pkg::BIT_EXT_PIN) | bm(rcf_pkg::BIT_SLEEP),
                         bm(rcf_pkg::BIT_WATCHDOG) | bm(rcf_pkg::BIT_IDLE));
      rcf_pkg::RCF_EV_PIN_IDLE:
        flags_next = upd(base, bm(rcf_pkg::BIT_EXT_PIN) | bm(rcf_pkg::BIT_IDLE),
                         bm(rcf_pkg::BIT_WATCHDOG) | bm(rcf_pkg::BIT_SLEEP));
      rcf_pkg::RCF_EV_WDT_RESET:
        flags_next = upd(base, bm(rcf_pkg::BIT_WATCHDOG), bm(rcf_pkg::BIT_EXT_PIN)
                         | bm(rcf_pkg::BIT_SOFTWARE) | bm(rcf_pkg::BIT_IDLE) | bm(rcf_pkg::BIT_SLEEP));
      rcf_pkg::RCF_EV_WDT_WAKE:
      begin
        flags_next      = upd(base, bm(rcf_pkg::BIT_WATCHDOG) | bm(rcf_pkg::BIT_SLEEP), '0);
        pc_value_next   = current_pc + rcf_pkg::PC_STEP;
        core_reset_next = 1'b0;
      end
      rcf_pkg::RCF_EV_INT_WAKE:
      begin
        flags_next      = upd(base, bm(rcf_pkg::BIT_SLEEP), '0);
        pc_value_next   = ev.vector;
        core_reset_next = 1'b0;
      end
      rcf_pkg::RCF_EV_CLK_FAIL:
      begin
        pc_value_next   = rcf_pkg::PC_TRAP;
        core_reset_next = 1'b0;
      end
      rcf_pkg::RCF_EV_TRAP_CONF:
        flags_next = upd(base, bm(rcf_pkg::BIT_TRAP_CONF), '0);
      rcf_pkg::RCF_EV_ILLEGAL:
        flags_next = upd(base, bm(rcf_pkg::BIT_ILLEGAL), '0);
      rcf_pkg::RCF_EV_NONE:
      begin
        pc_value_next   = pc_value_reg;
        pc_load_next    = 1'b0;
        core_reset_next = 1'b0;
        last_evt_next   = last_evt_reg;
      end
      default:
      begin
        pc_value_next   = pc_value_reg;
        pc_load_next    = 1'b0;
        core_reset_next = 1'b0;
        last_evt_next   = last_evt_reg;
      end
    endcase
    // Clock failure keeps every flag as it stands, no event sets BIT_CLK_FAIL, only a bus write can
    if (ev.evt == rcf_pkg::RCF_EV_CLK_FAIL)
      flags_next = base;
  end

  // ****************************************
  // Bus read path
  // ****************************************
  always_comb
  begin
    wait_next  = wait_comb;
    rdata_next = rdata_reg;
    // Loaded one cycle early so data stands at the handshake edge
    if (!wait_comb && avs_read)
    begin
      unique case (avs_address)
        rcf_pkg::OFF_CAUSE:    rdata_next = {{(32-rcf_pkg::FLAG_W){1'b0}}, flags_reg};
        rcf_pkg::OFF_PC:       rdata_next = {{(32-rcf_pkg::PC_W){1'b0}}, pc_value_reg};
        rcf_pkg::OFF_LAST_EVT: rdata_next = {28'h0000000, last_evt_reg};
        default:               rdata_next = rcf_pkg::BAD_ADDR_RD;
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      flags_reg      <= rcf_pkg::FLAGS_RESET;
      pc_load_reg    <= 1'b0;
      pc_value_reg   <= rcf_pkg::PC_RESET;
      core_reset_reg <= 1'b0;
      last_evt_reg   <= 4'h0;
      rdata_reg      <= 32'h00000000;
      wait_reg       <= 1'b1;
    end
    else
    begin
      flags_reg      <= flags_next;
      pc_load_reg    <= pc_load_next;
      pc_value_reg   <= pc_value_next;
      core_reset_reg <= core_reset_next;
      last_evt_reg   <= last_evt_next;
      rdata_reg      <= rdata_next;
      wait_reg       <= wait_next;
    end
  end

  assign pc_load         = pc_load_reg;
  assign pc_value        = pc_value_reg;
  assign core_reset      = core_reset_reg;
  assign avs_readdata    = rdata_reg;
  // Flop-driven handshake, low for exactly the answering cycle
  assign avs_waitrequest = wait_reg;

  // ****************************************
  // Checks
  // ****************************************
  a_por_flags: assert property (@(posedge clock) disable iff (!nrst)
    ev.evt == rcf_pkg::RCF_EV_POWER_ON |=> flags_reg == 10'h003 && pc_value_reg == 24'h000000)
    else $error("power-on flags wrong");
  a_bor_flags: assert property (@(posedge clock) disable iff (!nrst)
    ev.evt == rcf_pkg::RCF_EV_BROWNOUT |=> flags_reg[0] && !flags_reg[1])
    else $error("brownout flags wrong");
  a_pin_run: assert property (@(posedge clock) disable iff (!nrst)
    ev.evt == rcf_pkg::RCF_EV_PIN_RUN |=> flags_reg[6] && flags_reg[5:2] == 4'h0)
    else $error("pin reset flags wrong");
  a_soft_rst: assert property (@(posedge clock) disable iff (!nrst)
    ev.evt == rcf_pkg::RCF_EV_SOFTWARE |=> flags_reg[5] && !flags_reg[6] && flags_reg[4:2] == 3'h0)
    else $error("software reset flags wrong");
  a_pin_sleep: assert property (@(posedge clock) disable iff (!nrst)
    ev.evt == rcf_pkg::RCF_EV_PIN_SLEEP |=> flags_reg[6] && flags_reg[2] && !flags_reg[3] && !flags_reg[4])
    else $error("pin sleep flags wrong");
  a_pin_idle: assert property (@(posedge clock) disable iff (!nrst)
    ev.evt == rcf_pkg::RCF_EV_PIN_IDLE |=> flags_reg[6] && flags_reg[3] && !flags_reg[2] && !flags_reg[4])
    else $error("pin idle flags wrong");
  a_wdt_rst: assert property (@(posedge clock) disable iff (!nrst)
    ev.evt == rcf_pkg::RCF_EV_WDT_RESET |=> flags_reg[4] && flags_reg[6:5] == 2'h0 && core_reset_reg)
    else $error("watchdog reset flags wrong");
  a_wdt_wake: assert property (@(posedge clock) disable iff (!nrst)
    ev.evt == rcf_pkg::RCF_EV_WDT_WAKE |=> pc_value_reg == $past(current_pc) + 24'h000002 && !core_reset_reg)
    else $error("watchdog wake pc wrong");
  a_int_wake: assert property (@(posedge clock) disable iff (!nrst)
    ev.evt == rcf_pkg::RCF_EV_INT_WAKE |=> pc_value_reg == $past(int_vector) && flags_reg[2])
    else $error("interrupt wake wrong");
  a_clk_fail: assert property (@(posedge clock) disable iff (!nrst)
    ev.evt == rcf_pkg::RCF_EV_CLK_FAIL && !avs_write |=> pc_value_reg == 24'h000004 && $stable(flags_reg))
    else $error("clock failure trap wrong");
  a_trap_conf: assert property (@(posedge clock) disable iff (!nrst)
    ev.evt == rcf_pkg::RCF_EV_TRAP_CONF |=> flags_reg[8] && pc_value_reg == 24'h000000)
    else $error("trap conflict wrong");
  a_illegal_op: assert property (@(posedge clock) disable iff (!nrst)
    ev.evt == rcf_pkg::RCF_EV_ILLEGAL |=> flags_reg[7] && pc_value_reg == 24'h000000)
    else $error("illegal op wrong");
  a_flags_hold: assert property (@(posedge clock) disable iff (!nrst)
    ev.evt == rcf_pkg::RCF_EV_NONE && !(accept && avs_write) |=> $stable(flags_reg))
    else $error("flags changed without cause");
  a_sw_write: assert property (@(posedge clock) disable iff (!nrst)
    accept && avs_write && avs_address == 4'h0 && avs_byteenable == 4'hF && ev.evt == rcf_pkg::RCF_EV_NONE
    |=> flags_reg == $past(avs_writedata[9:0]))
    else $error("software write lost");

  c_por:      cover property (@(posedge clock) ev.evt == rcf_pkg::RCF_EV_POWER_ON);
  c_wdt_wake: cover property (@(posedge clock) ev.evt == rcf_pkg::RCF_EV_WDT_WAKE);
  c_pin_slp:  cover property (@(posedge clock) ev.evt == rcf_pkg::RCF_EV_PIN_SLEEP);
  c_wr_evt:   cover property (@(posedge clock) accept && avs_write && ev.evt != rcf_pkg::RCF_EV_NONE);

endmodule : rcf_reset_cause

/* File: test/rcf_cpu_model.sv */
module rcf_cpu_model
(
  input  wire logic                     clock,
  input  wire logic                     nrst,
  input  wire logic                     pc_load,
  input  wire logic [rcf_pkg::PC_W-1:0] pc_value,
  output logic      [rcf_pkg::PC_W-1:0] current_pc
);
  timeunit 1ns;
  timeprecision 1ps;
  // Core count stands still so a wake offset is easy to predict
  always_ff @(posedge clock or negedge nrst)
    if (!nrst)
      current_pc <= 24'h000100;
    else if (pc_load)
      current_pc <= pc_value;
endmodule : rcf_cpu_model

/* File: test/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic                       clock, nrst, power_on_evt, brownout_evt, master_clear_pin_n, cpu_in_sleep;
  logic                       cpu_in_idle, watchdog_timeout, software_reset, int_wake, clock_fail_trap;
  logic                       trap_conflict, illegal_op, avs_read, avs_write, pc_load, core_reset;
  logic                       avs_waitrequest;
  logic [rcf_pkg::PC_W-1:0]   int_vector, current_pc, pc_value;
  logic [rcf_pkg::ADDR_W-1:0] avs_address;
  logic [31:0]                avs_writedata, avs_readdata, rd;
  logic [3:0]                 avs_byteenable;
  int                         num_errors, num_checks, cycles;

  rcf_reset_cause dut_u (.clock, .nrst, .power_on_evt, .brownout_evt, .master_clear_pin_n, .cpu_in_sleep,
    .cpu_in_idle, .watchdog_timeout, .software_reset, .int_wake, .int_vector, .clock_fail_trap, .trap_conflict,
    .illegal_op, .current_pc, .pc_load, .pc_value, .core_reset, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest);
  rcf_cpu_model cpu_u (.clock, .nrst, .pc_load, .pc_value, .current_pc);

  always #4 clock = ~clock;
  // Ceiling well above the few hundred cycles the tests need
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      end_sim();
    end
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clock);
    avs_read       <= !wr;
    avs_write      <= wr;
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    do @(posedge clock); while (avs_waitrequest !== 1'h0);
    // Read data stands at the handshake edge
    rd        = avs_readdata;
    avs_read  <= 1'h0;
    avs_write <= 1'h0;
  endtask : bus

  task automatic run_ev(input rcf_pkg::rcf_event_t e, input logic [8:0] set, input logic [8:0] clr,
                        input logic [23:0] pc, input logic rst);
    logic [8:0]  p;
    logic [23:0] xpc;
    for (int i = 0; i < 2; i++)
    begin
      p = i ? 9'h1FF : 9'h000;
      bus(1'h1, rcf_pkg::OFF_CAUSE, {23'h0, p}, 4'hF);
      xpc = (e == rcf_pkg::RCF_EV_WDT_WAKE) ? current_pc + rcf_pkg::PC_STEP : pc;
      @(posedge clock);
      cpu_in_sleep       <= e inside {rcf_pkg::RCF_EV_PIN_SLEEP, rcf_pkg::RCF_EV_WDT_WAKE, rcf_pkg::RCF_EV_INT_WAKE};
      cpu_in_idle        <= e == rcf_pkg::RCF_EV_PIN_IDLE;
      master_clear_pin_n <= !(e inside {rcf_pkg::RCF_EV_PIN_RUN, rcf_pkg::RCF_EV_PIN_SLEEP, rcf_pkg::RCF_EV_PIN_IDLE});
      power_on_evt       <= e == rcf_pkg::RCF_EV_POWER_ON;
      brownout_evt       <= e == rcf_pkg::RCF_EV_BROWNOUT;
      watchdog_timeout   <= e inside {rcf_pkg::RCF_EV_WDT_RESET, rcf_pkg::RCF_EV_WDT_WAKE};
      software_reset     <= e == rcf_pkg::RCF_EV_SOFTWARE;
      int_wake           <= e == rcf_pkg::RCF_EV_INT_WAKE;
      clock_fail_trap    <= e == rcf_pkg::RCF_EV_CLK_FAIL;
      trap_conflict      <= e == rcf_pkg::RCF_EV_TRAP_CONF;
      illegal_op         <= e == rcf_pkg::RCF_EV_ILLEGAL;
      @(posedge clock);
      {power_on_evt, brownout_evt, watchdog_timeout, software_reset, int_wake} <= 5'h00;
      {clock_fail_trap, trap_conflict, illegal_op} <= 3'h0;
      #1;
      // Pin path is synchronised, so allow a few edges
      for (int n = 0; n < 8 && pc_load !== 1'h1; n++)
        @(posedge clock) #1;
      chk("pc_load", 1'h1, pc_load);
      chk("pc_value", xpc, pc_value);
      chk("core_reset", rst, core_reset);
      @(posedge clock);
      master_clear_pin_n <= 1'h1;
      cpu_in_sleep       <= 1'h0;
      cpu_in_idle        <= 1'h0;
      repeat (4) @(posedge clock);
      bus(1'h0, rcf_pkg::OFF_CAUSE, 32'h0, 4'hF);
      chk("flags", {23'h0, (p & ~clr) | set}, {23'h0, rd[8:0]});
      bus(1'h0, rcf_pkg::OFF_PC, 32'h0, 4'hF);
      chk("pc readback", {8'h00, xpc}, rd);
    end
  endtask : run_ev
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_bus;
    bus(1'h0, rcf_pkg::OFF_CAUSE, 32'h0, 4'hF);
    chk("flags after reset", 32'h003, rd);
    bus(1'h1, rcf_pkg::OFF_PC, 32'h00FFFF, 4'hF);
    bus(1'h0, rcf_pkg::OFF_PC, 32'h0, 4'hF);
    chk("pc register", 32'h0, rd);
    bus(1'h0, 4'hC, 32'h0, 4'hF);
    chk("unmapped read", 32'hDEADBEEF, rd);
    bus(1'h1, rcf_pkg::OFF_CAUSE, 32'h3FC, 4'h1);
    bus(1'h0, rcf_pkg::OFF_CAUSE, 32'h0, 4'hF);
    chk("partial write", 32'h0FC, rd);
    $display("test bus done");
  endtask : t_bus

  task automatic t_run_resets;
    run_ev(rcf_pkg::RCF_EV_POWER_ON, 9'h003, 9'h1FF, 24'h0, 1'h1);
    run_ev(rcf_pkg::RCF_EV_BROWNOUT, 9'h001, 9'h002, 24'h0, 1'h1);
    run_ev(rcf_pkg::RCF_EV_PIN_RUN, 9'h040, 9'h03C, 24'h0, 1'h1);
    run_ev(rcf_pkg::RCF_EV_SOFTWARE, 9'h020, 9'h05C, 24'h0, 1'h1);
    run_ev(rcf_pkg::RCF_EV_WDT_RESET, 9'h010, 9'h06C, 24'h0, 1'h1);
    $display("test run resets done");
  endtask : t_run_resets

  task automatic t_low_power;
    run_ev(rcf_pkg::RCF_EV_PIN_SLEEP, 9'h044, 9'h018, 24'h0, 1'h1);
    run_ev(rcf_pkg::RCF_EV_PIN_IDLE, 9'h048, 9'h014, 24'h0, 1'h1);
    run_ev(rcf_pkg::RCF_EV_INT_WAKE, 9'h004, 9'h000, 24'h00ABCD, 1'h0);
    run_ev(rcf_pkg::RCF_EV_WDT_WAKE, 9'h014, 9'h000, 24'h0, 1'h0);
    $display("test low power done");
  endtask : t_low_power

  task automatic t_traps;
    run_ev(rcf_pkg::RCF_EV_CLK_FAIL, 9'h000, 9'h000, 24'h000004, 1'h0);
    run_ev(rcf_pkg::RCF_EV_TRAP_CONF, 9'h100, 9'h000, 24'h0, 1'h1);
    run_ev(rcf_pkg::RCF_EV_ILLEGAL, 9'h080, 9'h000, 24'h0, 1'h1);
    $display("test traps done");
  endtask : t_traps

  task automatic end_sim;
    $display("checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim

  initial
  begin
    {clock, nrst, power_on_evt, brownout_evt, cpu_in_sleep, cpu_in_idle, watchdog_timeout} = 7'h00;
    {software_reset, int_wake, clock_fail_trap, trap_conflict, illegal_op, avs_read, avs_write} = 7'h00;
    master_clear_pin_n = 1'h1;
    int_vector         = 24'h00ABCD;
    avs_address        = 4'h0;
    avs_writedata      = 32'h0;
    avs_byteenable     = 4'hF;
    num_errors         = 0;
    num_checks         = 0;
    cycles             = 0;
    repeat (16) @(posedge clock);
    nrst <= 1'h1;
    t_bus();
    t_run_resets();
    t_low_power();
    t_traps();
    end_sim();
  end
endmodule : testbench
